// *** rtl/dma_host_ctrl.sv ***
// Host controller that programs the DMA controller registers from AXI4-Lite orders
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module dma_host_ctrl (
   input  wire logic                     aclk,
   input  wire logic                     aresetn,
   input  wire logic                     awvalid,
   output logic                          awready,
   input  wire logic [7:0]               awaddr,
   input  wire logic                     wvalid,
   output logic                          wready,
   input  wire logic [31:0]              wdata,
   input  wire logic [3:0]               wstrb,
   output logic                          bvalid,
   input  wire logic                     bready,
   output logic [1:0]                    bresp,
   input  wire logic                     arvalid,
   output logic                          arready,
   input  wire logic [7:0]               araddr,
   output logic                          rvalid,
   input  wire logic                     rready,
   output logic [31:0]                   rdata,
   output logic [1:0]                    rresp,
   output logic                          dev_valid,
   input  wire logic                     dev_ready,
   output dma_host_pkg::dev_cmd_t        dev_cmd,
   input  wire logic [31:0]              dev_rdata
);
   // AXI slave state
   logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [7:0]  aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt;
   logic [3:0]  w_strb_r, w_strb_nxt;
   logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
   logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [31:0] src_r, src_nxt, dst_r, dst_nxt, cnt_r, cnt_nxt, ctl_r, ctl_nxt;
   logic [1:0]  chan_r, chan_nxt;
   logic [2:0]  cmd_p;
   logic [3:0]  stat_clr;
   // Sequencer state
   dma_host_pkg::st_t      state_r, state_nxt;
   logic [1:0]             ch_r, ch_nxt;
   logic [31:0]            rd_r, rd_nxt;
   logic                   eaddr_r, eaddr_nxt, ecfg_r, ecfg_nxt, sbyok_r, sbyok_nxt;
   logic                   dv_r, dv_nxt, stop_r, stop_nxt;
   dma_host_pkg::dev_cmd_t cmd_r, cmd_nxt;
   logic                   busy, bad_addr, bad_cfg, acc_done;
   logic [7:0]             base;
   logic [31:0]            stat_w;

   function automatic logic forbidden(input logic [31:0] a);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < 3; i++) begin
         if (a >= dma_host_pkg::FORB_LO[i] && a <= dma_host_pkg::FORB_HI[i]) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] m;
      m = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            m[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return m;
   endfunction

   assign busy     = (state_r != dma_host_pkg::S_IDLE);
   assign stat_w   = {28'h0, sbyok_r, ecfg_r, eaddr_r, busy};
   assign acc_done = dv_r && dev_ready;
   assign bad_addr = forbidden(src_r) || forbidden(dst_r);
   // Reload channel needs burst mode and a count in steps of four
   assign bad_cfg  = (ctl_r[dma_host_pkg::RS_LSB +: 5] == dma_host_pkg::RS_NOREQ)
                     || (chan_r == 2'(dma_host_pkg::RELOAD_CH) && ctl_r[dma_host_pkg::RELOAD_BIT]
                         && (!ctl_r[dma_host_pkg::BURST_BIT]
                             || cnt_r[1:0] != 2'h0));

   // AXI4-Lite slave
   always_comb begin
      aw_hold_nxt = aw_hold_r;
      w_hold_nxt  = w_hold_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = bvalid_r && !bready;
      bresp_nxt   = bresp_r;
      rvalid_nxt  = rvalid_r && !rready;
      rresp_nxt   = rresp_r;
      rdata_nxt   = rdata_r;
      src_nxt     = src_r;
      dst_nxt     = dst_r;
      cnt_nxt     = cnt_r;
      ctl_nxt     = ctl_r;
      chan_nxt    = chan_r;
      cmd_p       = 3'h0;
      stat_clr    = 4'h0;
      if (awvalid && awready) begin
         aw_hold_nxt = 1'b1;
         aw_addr_nxt = awaddr;
      end
      if (wvalid && wready) begin
         w_hold_nxt = 1'b1;
         w_data_nxt = wdata;
         w_strb_nxt = wstrb;
      end
      if (aw_hold_r && w_hold_r && !bvalid_r) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = dma_host_pkg::RESP_OKAY;
         // Settings freeze while a sequence runs so checks stay valid
         case (aw_addr_r)
            dma_host_pkg::A_SRC: if (!busy) src_nxt = merge(src_r, w_data_r, w_strb_r);
            dma_host_pkg::A_DST: if (!busy) dst_nxt = merge(dst_r, w_data_r, w_strb_r);
            dma_host_pkg::A_CNT: if (!busy) cnt_nxt = merge(cnt_r, w_data_r, w_strb_r);
            dma_host_pkg::A_CTL: if (!busy) ctl_nxt = merge(ctl_r, w_data_r, w_strb_r);
            dma_host_pkg::A_CHAN: if (!busy && w_strb_r[0]) chan_nxt = w_data_r[1:0];
            dma_host_pkg::A_CMD: if (w_strb_r[0]) cmd_p = w_data_r[2:0];
            dma_host_pkg::A_STAT: if (w_strb_r[0]) stat_clr = w_data_r[3:0];
            dma_host_pkg::A_RDBK: ;
            default: bresp_nxt = dma_host_pkg::RESP_SLV;
         endcase
      end
      if (arvalid && arready) begin
         rvalid_nxt = 1'b1;
         rresp_nxt  = dma_host_pkg::RESP_OKAY;
         case (araddr)
            dma_host_pkg::A_SRC:  rdata_nxt = src_r;
            dma_host_pkg::A_DST:  rdata_nxt = dst_r;
            dma_host_pkg::A_CNT:  rdata_nxt = cnt_r;
            dma_host_pkg::A_CTL:  rdata_nxt = ctl_r;
            dma_host_pkg::A_CHAN: rdata_nxt = {30'h0, chan_r};
            dma_host_pkg::A_CMD:  rdata_nxt = 32'h0;
            dma_host_pkg::A_STAT: rdata_nxt = stat_w;
            dma_host_pkg::A_RDBK: rdata_nxt = rd_r;
            default: begin
               rdata_nxt = 32'h0;
               rresp_nxt = dma_host_pkg::RESP_SLV;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         aw_addr_r <= 8'h0;
         w_data_r  <= 32'h0;
         w_strb_r  <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= 2'h0;
         rvalid_r  <= 1'b0;
         rresp_r   <= 2'h0;
         rdata_r   <= 32'h0;
         src_r     <= 32'h0;
         dst_r     <= 32'h0;
         cnt_r     <= 32'h0;
         ctl_r     <= 32'h0;
         chan_r    <= 2'h0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r  <= w_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_data_r  <= w_data_nxt;
         w_strb_r  <= w_strb_nxt;
         bvalid_r  <= bvalid_nxt;
         bresp_r   <= bresp_nxt;
         rvalid_r  <= rvalid_nxt;
         rresp_r   <= rresp_nxt;
         rdata_r   <= rdata_nxt;
         src_r     <= src_nxt;
         dst_r     <= dst_nxt;
         cnt_r     <= cnt_nxt;
         ctl_r     <= ctl_nxt;
         chan_r    <= chan_nxt;
      end
   end

   assign awready = !aw_hold_r && !bvalid_r;
   assign wready  = !w_hold_r && !bvalid_r;
   assign arready = !rvalid_r;
   assign bvalid  = bvalid_r;
   assign bresp   = bresp_r;
   assign rvalid  = rvalid_r;
   assign rresp   = rresp_r;
   assign rdata   = rdata_r;

   // Register-programming sequencer
   always_comb begin
      state_nxt = state_r;
      ch_nxt    = ch_r;
      rd_nxt    = rd_r;
      // Remember the order kind; the enable-clear step alone cannot tell stop from start
      stop_nxt  = (state_r == dma_host_pkg::S_IDLE) ? (cmd_p[dma_host_pkg::CMD_STOP] && !cmd_p[dma_host_pkg::CMD_START]) : stop_r;
      // Hardware set wins over a same-cycle software clear
      eaddr_nxt = eaddr_r && !stat_clr[dma_host_pkg::ST_EADDR];
      ecfg_nxt  = ecfg_r && !stat_clr[dma_host_pkg::ST_ECFG];
      sbyok_nxt = sbyok_r && !stat_clr[dma_host_pkg::ST_SBYOK];
      case (state_r)
         dma_host_pkg::S_IDLE: begin
            if (cmd_p[dma_host_pkg::CMD_START]) begin
               eaddr_nxt = eaddr_nxt || bad_addr;
               ecfg_nxt  = ecfg_nxt || bad_cfg;
               if (!bad_addr && !bad_cfg) begin
                  state_nxt = dma_host_pkg::S_RDCTL;
                  ch_nxt    = chan_r;
               end
            end else if (cmd_p[dma_host_pkg::CMD_STOP]) begin
               state_nxt = dma_host_pkg::S_RDCTL;
               ch_nxt    = chan_r;
            end else if (cmd_p[dma_host_pkg::CMD_SBY]) begin
               state_nxt = dma_host_pkg::S_SBOFF;
               ch_nxt    = 2'h0;
               sbyok_nxt = 1'b0;
            end
         end
         dma_host_pkg::S_RDCTL: if (acc_done) begin
            rd_nxt    = dev_rdata;
            state_nxt = dma_host_pkg::S_CLRDE;
         end
         // Stop ends after the enable clear; start goes on to reprogram
         dma_host_pkg::S_CLRDE: if (acc_done) state_nxt = stop_r ? dma_host_pkg::S_IDLE : dma_host_pkg::S_ZCNT;
         dma_host_pkg::S_ZCNT: if (acc_done) state_nxt = dma_host_pkg::S_WSRC;
         dma_host_pkg::S_WSRC: if (acc_done) state_nxt = dma_host_pkg::S_WDST;
         dma_host_pkg::S_WDST: if (acc_done) state_nxt = dma_host_pkg::S_WCNT;
         dma_host_pkg::S_WCNT: if (acc_done) state_nxt = dma_host_pkg::S_WCTL;
         dma_host_pkg::S_WCTL: if (acc_done) state_nxt = dma_host_pkg::S_WME;
         dma_host_pkg::S_WME: if (acc_done) state_nxt = dma_host_pkg::S_IDLE;
         dma_host_pkg::S_SBOFF: if (acc_done) state_nxt = dma_host_pkg::S_POLL;
         // Poll each channel until disabled or finished; no timeout by design
         dma_host_pkg::S_POLL: if (acc_done && (!dev_rdata[dma_host_pkg::DE_BIT]
                                   || dev_rdata[dma_host_pkg::TE_BIT])) begin
            rd_nxt = dev_rdata;
            if (ch_r == 2'(dma_host_pkg::NCH - 1)) begin
               state_nxt = dma_host_pkg::S_IDLE;
               sbyok_nxt = 1'b1;
            end else begin
               ch_nxt = ch_r + 2'h1;
            end
         end
         default: state_nxt = dma_host_pkg::S_IDLE;
      endcase
   end

   // Access issued for the coming state; only mapped offsets exist here
   always_comb begin
      base    = 8'(ch_nxt) << dma_host_pkg::CH_SHIFT;
      dv_nxt  = (state_nxt != dma_host_pkg::S_IDLE);
      cmd_nxt = '{wr: 1'b1, wide: 1'b1, addr: base | dma_host_pkg::D_CTL, wdata: 32'h0};
      case (state_nxt)
         dma_host_pkg::S_RDCTL, dma_host_pkg::S_POLL: cmd_nxt.wr = 1'b0;
         // Clear only the enable; a start's new request source follows later
         dma_host_pkg::S_CLRDE: cmd_nxt.wdata = rd_nxt & ~(32'h1 << dma_host_pkg::DE_BIT);
         dma_host_pkg::S_ZCNT: cmd_nxt.addr = base | dma_host_pkg::D_CNT;
         dma_host_pkg::S_WSRC: begin
            cmd_nxt.addr  = base | dma_host_pkg::D_SRC;
            cmd_nxt.wdata = src_r;
         end
         dma_host_pkg::S_WDST: begin
            cmd_nxt.addr  = base | dma_host_pkg::D_DST;
            cmd_nxt.wdata = dst_r;
         end
         dma_host_pkg::S_WCNT: begin
            cmd_nxt.addr  = base | dma_host_pkg::D_CNT;
            cmd_nxt.wdata = cnt_r;
         end
         dma_host_pkg::S_WCTL: cmd_nxt.wdata = ctl_r | (32'h1 << dma_host_pkg::DE_BIT);
         dma_host_pkg::S_WME, dma_host_pkg::S_SBOFF: begin
            cmd_nxt.addr  = dma_host_pkg::D_OPR;
            cmd_nxt.wide  = 1'b0;
            cmd_nxt.wdata = (state_nxt == dma_host_pkg::S_WME) ? {16'h0, dma_host_pkg::OPR_ME} : 32'h0;
         end
         default: cmd_nxt.wr = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r <= dma_host_pkg::S_IDLE;
         ch_r    <= 2'h0;
         rd_r    <= 32'h0;
         eaddr_r <= 1'b0;
         ecfg_r  <= 1'b0;
         sbyok_r <= 1'b0;
         dv_r    <= 1'b0;
         stop_r  <= 1'b0;
         cmd_r   <= '0;
      end else begin
         state_r <= state_nxt;
         ch_r    <= ch_nxt;
         rd_r    <= rd_nxt;
         eaddr_r <= eaddr_nxt;
         ecfg_r  <= ecfg_nxt;
         sbyok_r <= sbyok_nxt;
         dv_r    <= dv_nxt;
         stop_r  <= stop_nxt;
         cmd_r   <= cmd_nxt;
      end
   end

   assign dev_valid = dv_r;
   assign dev_cmd   = cmd_r;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_opr_half_width: assert property (dev_valid && dev_cmd.addr == dma_host_pkg::D_OPR |-> !dev_cmd.wide)
      else $error("operation register accessed wide");
   a_chan_full_width: assert property (dev_valid && dev_cmd.addr != dma_host_pkg::D_OPR |-> dev_cmd.wide)
      else $error("channel register accessed narrow");
   a_de_cleared_first: assert property ($rose(state_r == dma_host_pkg::S_ZCNT) |-> $past(state_r) == dma_host_pkg::S_CLRDE
      && !$past(dev_cmd.wdata[dma_host_pkg::DE_BIT]))
      else $error("request source changed without enable cleared");
   a_ctl_written_last: assert property ($rose(state_r == dma_host_pkg::S_WCTL) |-> $past(state_r) == dma_host_pkg::S_WCNT)
      else $error("channel control not written last");
   a_count_zeroed: assert property ($rose(state_r == dma_host_pkg::S_WSRC) |-> $past(state_r) == dma_host_pkg::S_ZCNT
      && $past(dev_cmd.wdata) == 32'h0)
      else $error("count not zeroed before reuse");
   a_no_forbidden_ep: assert property (state_r == dma_host_pkg::S_WSRC |-> !forbidden(src_r) && !forbidden(dst_r))
      else $error("forbidden endpoint programmed");
   a_reload_burst: assert property (state_r == dma_host_pkg::S_WCTL && ch_r == 2'(dma_host_pkg::RELOAD_CH)
      && dev_cmd.wdata[dma_host_pkg::RELOAD_BIT] |-> dev_cmd.wdata[dma_host_pkg::BURST_BIT])
      else $error("reload without burst mode");
   a_reload_count4: assert property (state_r == dma_host_pkg::S_WCTL && ch_r == 2'(dma_host_pkg::RELOAD_CH)
      && dev_cmd.wdata[dma_host_pkg::RELOAD_BIT] |-> cnt_r[1:0] == 2'h0)
      else $error("reload count not multiple of four");
   a_enable_has_source: assert property (dev_valid && dev_cmd.wr && dev_cmd.addr[3:0] == dma_host_pkg::D_CTL[3:0]
      && dev_cmd.addr != dma_host_pkg::D_OPR && dev_cmd.wdata[dma_host_pkg::DE_BIT]
      |-> dev_cmd.wdata[dma_host_pkg::RS_LSB +: 5] != dma_host_pkg::RS_NOREQ)
      else $error("enable set with no request source");
   a_mapped_only: assert property (dev_valid |-> dev_cmd.addr == dma_host_pkg::D_OPR
      || (dev_cmd.addr < 8'(dma_host_pkg::NCH * 16) && dev_cmd.addr[1:0] == 2'h0))
      else $error("unmapped device address");
   a_standby_order: assert property ($rose(sbyok_r) |-> $past(state_r) == dma_host_pkg::S_POLL)
      else $error("standby ready without polling");
   a_dev_hold: assert property (dev_valid && !dev_ready |=> dev_valid && $stable(dev_cmd))
      else $error("device request dropped before taken");

   c_start_done: cover property ($rose(state_r == dma_host_pkg::S_WME));
   c_stop_done: cover property ($fell(busy) && $past(state_r) == dma_host_pkg::S_CLRDE);
   c_standby_ok: cover property ($rose(sbyok_r));
   c_start_refused: cover property ($rose(ecfg_r) || $rose(eaddr_r));
endmodule

// *** include/dma_host_pkg.sv ***
// Constants and carriers for the DMA register-programming host controller
// Contract
// - Operation register takes 16-bit accesses only; others 16 or 32 bits.
// - Clear channel_enable to 0 before changing request_source_select.
// - Before standby, clear master_enable and confirm accepted transfers finished.
// - Never use controller, bus_state_controller or break_controller registers as endpoints.
// - Program channel_control_register after all other channel registers.
// - After count reaches 0 normally, write 0 to transfer_count_register before reuse.
// - Address reload requires burst bus mode, not cycle-steal.
// - With address reload, transfer count must be a multiple of four.
// - Never access unused addresses in the controller register space.
// - Aborts stop transfers; reprogram reload channel source, destination, count after.
// - Never set channel_enable while request_source_select encodes no-request.
package dma_host_pkg;
   localparam int         NCH        = 4;
   localparam int         RELOAD_CH  = 2;
   // Device register map
   localparam logic [7:0] CH_SHIFT   = 8'h04;
   localparam logic [7:0] D_SRC      = 8'h00;
   localparam logic [7:0] D_DST      = 8'h04;
   localparam logic [7:0] D_CNT      = 8'h08;
   localparam logic [7:0] D_CTL      = 8'h0c;
   localparam logic [7:0] D_OPR      = 8'h40;
   // Channel control fields
   localparam int         DE_BIT     = 0;
   localparam int         TE_BIT     = 1;
   localparam int         BURST_BIT  = 4;
   localparam int         RS_LSB     = 8;
   localparam int         RELOAD_BIT = 24;
   localparam logic [4:0] RS_NOREQ   = 5'h00;
   localparam logic [15:0] OPR_ME    = 16'h0001;
   // Forbidden endpoint windows: own, bus state, break controller
   localparam logic [2:0][31:0] FORB_LO = {32'hfff0_0000, 32'hfff1_0000, 32'hfff2_0000};
   localparam logic [2:0][31:0] FORB_HI = {32'hfff0_00ff, 32'hfff1_00ff, 32'hfff2_00ff};
   // Host register map
   localparam logic [7:0] A_SRC      = 8'h00;
   localparam logic [7:0] A_DST      = 8'h04;
   localparam logic [7:0] A_CNT      = 8'h08;
   localparam logic [7:0] A_CTL      = 8'h0c;
   localparam logic [7:0] A_CHAN     = 8'h10;
   localparam logic [7:0] A_CMD      = 8'h14;
   localparam logic [7:0] A_STAT     = 8'h18;
   localparam logic [7:0] A_RDBK     = 8'h1c;
   localparam int         CMD_START  = 0;
   localparam int         CMD_STOP   = 1;
   localparam int         CMD_SBY    = 2;
   localparam int         ST_BUSY    = 0;
   localparam int         ST_EADDR   = 1;
   localparam int         ST_ECFG    = 2;
   localparam int         ST_SBYOK   = 3;
   localparam logic [1:0] RESP_OKAY  = 2'h0;
   localparam logic [1:0] RESP_SLV   = 2'h2;

   typedef struct packed {
      logic        wr;
      logic        wide;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } dev_cmd_t;

   typedef enum logic [10:0] {
      S_IDLE  = 11'h001,
      S_RDCTL = 11'h002,
      S_CLRDE = 11'h004,
      S_ZCNT  = 11'h008,
      S_WSRC  = 11'h010,
      S_WDST  = 11'h020,
      S_WCNT  = 11'h040,
      S_WCTL  = 11'h080,
      S_WME   = 11'h100,
      S_SBOFF = 11'h200,
      S_POLL  = 11'h400
   } st_t;
endpackage

// *** tb/dma_dev_model.sv ***
// Behavioural model of the DMA controller register port
`timescale 1ns/1ps
module dma_dev_model (
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   input  wire logic                   slow,
   input  wire logic                   nmi,
   input  wire logic                   dev_valid,
   output logic                        dev_ready,
   input  wire dma_host_pkg::dev_cmd_t dev_cmd,
   output logic [31:0]                 dev_rdata
);
   logic [31:0] regs [4][4];
   logic [3:0]  wmask [4];
   logic        zeroed [4];
   logic [15:0] opr;
   logic [31:0] last, d, rd;
   logic [1:0]  tick, ch, r;
   int          viol;
   assign ch = dev_cmd.addr[5:4];
   assign r = dev_cmd.addr[3:2];
   assign d = dev_cmd.wdata;
   // Slow mode answers one cycle in four
   assign dev_ready = dev_valid && (!slow || tick == 2'h3);
   // Master enable off halts channels, so enabled ones report end
   assign rd = (dev_cmd.addr == 8'h40) ? {16'h0, opr} :
               regs[ch][r] | {30'h0, r == 2'h3 && !opr[0] && regs[ch][3][0], 1'b0};
   // Idle bus never repeats the last answer
   assign dev_rdata = (dev_ready && !dev_cmd.wr) ? rd : ~last ^ {30'h0, tick};
   always @(posedge aclk) begin
      tick <= tick + 2'h1;
      if (!aresetn) begin
         tick <= 2'h0;
         opr <= 16'h0;
         last <= 32'h0;
         viol = 0;
         for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 4; j++) begin
               regs[i][j] <= 32'h0;
            end
            wmask[i] <= 4'h0;
            zeroed[i] <= 1'b1;
         end
      end else begin
         if (nmi) opr[1] <= 1'b1;
         if (dev_ready) last <= dev_rdata;
         if (dev_ready && dev_cmd.wr && dev_cmd.addr == 8'h40) begin
            if (dev_cmd.wide) viol++;
            opr[0] <= d[0];
         end else if (dev_ready && dev_cmd.wr && dev_cmd.addr[7:6] != 2'h0) begin
            viol++;
         end else if (dev_ready && dev_cmd.wr) begin
            regs[ch][r] <= d;
            wmask[ch][r] <= 1'b1;
            if (r < 2'h2 && d[31:20] == 12'hfff && d[19:16] < 4'h3 && d[15:8] == 8'h0) viol++;
            if (r == 2'h2) begin
               if (d != 32'h0 && !zeroed[ch]) viol++;
               zeroed[ch] <= (d == 32'h0);
            end
            if (r == 2'h3) begin
               if (regs[ch][3][0] && regs[ch][3][12:8] != d[12:8]) viol++;
               if (d[0] && (d[12:8] == 5'h0 || wmask[ch][2:0] != 3'h7)) viol++;
               if (d[0] && ch == 2'h2 && d[24] && (!d[4] || regs[2][2][1:0] != 2'h0)) viol++;
               wmask[ch] <= 4'h0;
            end
         end
      end
   end
endmodule

// *** tb/dma_host_ctrl_tb.sv ***
// Self-checking bench for the DMA register-programming host controller
`timescale 1ns/1ps
module dma_host_ctrl_tb;
   logic                   aclk = 1'b0, aresetn = 1'b0, slow = 1'b0, nmi = 1'b0;
   logic                   awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [7:0]             awaddr = 8'h0, araddr = 8'h0;
   logic [31:0]            wdata = 32'h0;
   logic [3:0]             wstrb = 4'hf;
   logic                   awready, wready, bvalid, arready, rvalid, dev_valid, dev_ready;
   logic [1:0]             bresp, rresp, lr;
   logic [31:0]            rdata, dev_rdata, rv;
   dma_host_pkg::dev_cmd_t dev_cmd;
   int                     n_fail = 0, samples_checked = 0;
   dma_host_ctrl i_dma_host_ctrl (.aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
      .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
      .dev_valid, .dev_ready, .dev_cmd, .dev_rdata);
   dma_dev_model i_dma_dev_model (.aclk, .aresetn, .slow, .nmi, .dev_valid, .dev_ready, .dev_cmd, .dev_rdata);
   always #10 aclk = ~aclk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, lt, lw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge aclk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      do begin
         @(negedge aclk);
         lt = awvalid && awready;
         lw = wvalid && wready;
         @(posedge aclk);
         if (lt) awvalid <= 1'b0;
         if (lw) wvalid <= 1'b0;
         ta |= lt;
         tw |= lw;
      end while (!(ta && tw));
      do @(negedge aclk); while (bvalid !== 1'b1);
      lr = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(negedge aclk); while (arready !== 1'b1);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (rvalid !== 1'b1);
      rv = rdata;
      lr = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask
   // Busy polling is bounded only by the watchdog
   task automatic run_cmd(input logic [1:0] ch, input logic [31:0] cmd);
      axi_wr(dma_host_pkg::A_CHAN, {30'h0, ch});
      axi_wr(dma_host_pkg::A_CMD, cmd);
      do axi_rd(dma_host_pkg::A_STAT); while (rv[0] !== 1'b0);
   endtask
   task automatic start(input logic [1:0] ch, input logic [31:0] s, input logic [31:0] d,
                        input logic [31:0] c, input logic [31:0] t);
      axi_wr(dma_host_pkg::A_SRC, s);
      axi_wr(dma_host_pkg::A_DST, d);
      axi_wr(dma_host_pkg::A_CNT, c);
      axi_wr(dma_host_pkg::A_CTL, t);
      run_cmd(ch, 32'h1);
   endtask
   task automatic s_unmapped();
      axi_rd(8'h24);
      chk({30'h0, lr}, {30'h0, dma_host_pkg::RESP_SLV});
      chk(rv, 32'h0);
      axi_wr(8'h28, 32'h5);
      chk({30'h0, lr}, {30'h0, dma_host_pkg::RESP_SLV});
   endtask
   task automatic s_start();
      start(2'h1, 32'h1000_0000, 32'h2000_0000, 32'h40, 32'h300);
      chk(rv, 32'h0);
      chk(i_dma_dev_model.regs[1][0], 32'h1000_0000);
      chk(i_dma_dev_model.regs[1][3], 32'h301);
      chk({16'h0, i_dma_dev_model.opr}, 32'h1);
      chk(i_dma_dev_model.viol, 32'h0);
   endtask
   task automatic s_restart_slow();
      slow <= 1'b1;
      start(2'h1, 32'h1000_0100, 32'h2000_0100, 32'h80, 32'h500);
      chk(i_dma_dev_model.regs[1][2], 32'h80);
      chk(i_dma_dev_model.regs[1][3], 32'h501);
      chk(i_dma_dev_model.viol, 32'h0);
      axi_rd(dma_host_pkg::A_RDBK);
      chk(rv, 32'h301);
      slow <= 1'b0;
   endtask
   task automatic s_forbidden();
      for (int k = 0; k < 3; k++) begin
         start(2'h0, dma_host_pkg::FORB_HI[k], 32'h3000_0000, 32'h10, 32'h300);
         chk(rv & 32'h6, 32'h2);
         axi_wr(dma_host_pkg::A_STAT, 32'he);
         start(2'h0, 32'h3000_0000, dma_host_pkg::FORB_LO[k], 32'h10, 32'h300);
         chk(rv & 32'h6, 32'h2);
         axi_wr(dma_host_pkg::A_STAT, 32'he);
      end
      axi_rd(dma_host_pkg::A_STAT);
      chk(rv, 32'h0);
      chk(i_dma_dev_model.regs[0][3], 32'h0);
   endtask
   task automatic cfg_case(input logic [1:0] ch, input logic [31:0] c, input logic [31:0] t, input logic e);
      start(ch, 32'h4000_0000, 32'h5000_0000, c, t);
      chk(rv & 32'h6, {29'h0, e, 2'h0});
      axi_wr(dma_host_pkg::A_STAT, 32'he);
   endtask
   task automatic s_config();
      cfg_case(2'h0, 32'h8, 32'h0000_0000, 1'b1);
      cfg_case(2'h2, 32'h8, 32'h0100_0300, 1'b1);
      cfg_case(2'h2, 32'h6, 32'h0100_0310, 1'b1);
      cfg_case(2'h2, 32'h8, 32'h0100_0310, 1'b0);
      chk(i_dma_dev_model.regs[2][3], 32'h0100_0311);
      chk(i_dma_dev_model.regs[0][3], 32'h0);
   endtask
   task automatic s_stop_standby();
      run_cmd(2'h2, 32'h2);
      chk(i_dma_dev_model.regs[2][3], 32'h0100_0310);
      run_cmd(2'h0, 32'h4);
      chk(rv & 32'h8, 32'h8);
      chk({31'h0, i_dma_dev_model.opr[0]}, 32'h0);
      chk(i_dma_dev_model.viol, 32'h0);
      nmi <= 1'b1;
      @(posedge aclk);
      nmi <= 1'b0;
      @(posedge aclk);
      chk({31'h0, i_dma_dev_model.opr[1]}, 32'h1);
   endtask
   task automatic print_verdict();
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge aclk);
      chk({awready, wready, arready, bvalid, rvalid, dev_valid}, 32'h38);
      aresetn <= 1'b1;
      s_unmapped();
      s_start();
      s_restart_slow();
      s_forbidden();
      s_config();
      s_stop_standby();
      print_verdict();
   end
   // Generous span: the slow device stretches the restart in s_restart_slow
   initial begin
      repeat (30000) @(posedge aclk);
      n_fail++;
      print_verdict();
   end
endmodule
